// file: common/sfe_cfg.svh
// Constants for the serial flash erase / write-enable / sector protection block.
// Assumes inclusion by the design module and the testbench files; definitions only.
//
// Function
// (RQ1) Two chip erase opcodes act identically
// (RQ2) Modifying commands need write enable latch set
// (RQ3) Chip erase: no address, starts at deselect
// (RQ4) Partial byte: no erase, latch cleared
// (RQ5) Any protected sector blocks chip erase
// (RQ6) Busy during erase, latch cleared before end
// (RQ7) Erase failures raise the error flag
// (RQ8) Host should poll status for completion
// (RQ9) Write enable sets latch at deselect
// (RQ10) Incomplete enable/disable leaves latch unchanged
// (RQ11) Write disable clears latch at deselect
// (RQ12) One protect bit per sector, set at power-up
// (RQ13) Protected sectors reject program and erase
// (RQ14) Protect sector sets bit, clears latch
// (RQ15) Short protect aborts, latch cleared
// (RQ16) Unprotect sector clears bit, clears latch
// (RQ17) Short unprotect aborts, latch cleared
// (RQ18) Locked protection registers ignore protect commands
// (RQ19) Bits MSB first, 24-bit address high first
`ifndef SFE_CFG_SVH
`define SFE_CFG_SVH

// ----------------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------------
`define SFE_OP_CHIP_ERASE_A 8'h60
`define SFE_OP_CHIP_ERASE_B 8'hC7
`define SFE_OP_WRITE_EN     8'h06
`define SFE_OP_WRITE_DIS    8'h04
`define SFE_OP_PROTECT      8'h36
`define SFE_OP_UNPROTECT    8'h39

// ----------------------------------------------------------------------------
// Geometry and reset values
// ----------------------------------------------------------------------------
`define SFE_NUM_SECTORS     16
`define SFE_SECT_MSB        23
`define SFE_SECT_LSB        16
`define SFE_PROT_RESET      16'hFFFF
`define SFE_ADDR_BYTES      3'h3

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SFE_CHIP_ERASE_MS   8000
`define SFE_CLK_MHZ         100
`define SFE_CHIP_ERASE_CYC  (`SFE_CHIP_ERASE_MS * 1000 * `SFE_CLK_MHZ)
`define SFE_WEL_CLR_LEFT    32'h0000_0010

`endif

// file: common/sfe_pkg.sv
// Types for the serial flash erase / protection block.
// Assumes sfe_cfg.svh in the include path.
package sfe_pkg;
    typedef enum logic [1:0] {
        SFE_ST_IDLE  = 2'b00,
        SFE_ST_ERASE = 2'b01,
        SFE_ST_DONE  = 2'b11
    } sfe_state_t;

    typedef enum logic [2:0] {
        SFE_CMD_NONE,
        SFE_CMD_ERASE,
        SFE_CMD_WREN,
        SFE_CMD_WRDI,
        SFE_CMD_PROT,
        SFE_CMD_UNPROT
    } sfe_cmd_t;
endpackage

// file: verilog/sfe_sync.sv
// Two-flop synchroniser for pins from outside the clk_sys domain.
// Assumes a free-running clk_sys; the output lags the pin by two edges.
`timescale 1ns/100ps
module sfe_sync #(
    parameter logic INIT = 1'b0
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic reset_n,
    // Data
    input  wire logic d_in,
    output logic      d_out
);
    logic meta_r;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            meta_r <= INIT;
            d_out  <= INIT;
        end else begin
            meta_r <= d_in;
            d_out  <= meta_r;
        end
    end
endmodule

// file: verilog/sfe_core.sv
// Serial flash command sequencer: chip erase, write-enable latch, sector protection.
// Assumes SPI mode 0/3 pins from the host, oversampled by clk_sys (100 MHz)
// well above the serial clock rate, with each serial clock half period at
// least three clk_sys cycles and select high at least four cycles between
// frames; erase_fail, lockdown_any and the lock flag come from clk_sys logic.
`timescale 1ns/100ps
`include "sfe_cfg.svh"
module sfe_core #(
    parameter int unsigned ERASE_CYCLES = `SFE_CHIP_ERASE_CYC
) (
    // Clock and reset
    clk_sys,
    reset_n,
    // Serial pins
    spi_cs_n,
    spi_sck,
    spi_si,
    // Status inputs
    protection_regs_locked_flag,
    lockdown_any,
    erase_fail,
    // Status outputs
    busy,
    write_enable_latch,
    erase_program_error_flag,
    sector_protect,
    erase_start
);
    import sfe_pkg::*;

    // Clock and reset
    input  wire logic                          clk_sys;
    input  wire logic                          reset_n;
    // Serial pins
    input  wire logic                          spi_cs_n;
    input  wire logic                          spi_sck;
    input  wire logic                          spi_si;
    // Status inputs
    input  wire logic                          protection_regs_locked_flag;
    input  wire logic                          lockdown_any;
    input  wire logic                          erase_fail;
    // Status outputs
    output logic                               busy;
    output logic                               write_enable_latch;
    output logic                               erase_program_error_flag;
    output logic [`SFE_NUM_SECTORS-1:0]        sector_protect;
    output logic                               erase_start;

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    logic cs_n_s;
    logic sck_s;
    logic si_s;

    // Reset values match the idle pins, so no false edge follows reset
    sfe_sync #(.INIT(1'b1)) u_sync_cs (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .d_in    (spi_cs_n),
        .d_out   (cs_n_s)
    );

    sfe_sync #(.INIT(1'b0)) u_sync_sck (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .d_in    (spi_sck),
        .d_out   (sck_s)
    );

    sfe_sync #(.INIT(1'b0)) u_sync_si (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .d_in    (spi_si),
        .d_out   (si_s)
    );

    // ------------------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------------------
    logic cs_n_d_r;
    logic sck_d_r;
    logic sck_rise;
    logic cs_rise;
    logic cs_fall;

    // Delayed copies start at the idle pin levels
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            cs_n_d_r <= 1'b1;
            sck_d_r  <= 1'b0;
        end else begin
            cs_n_d_r <= cs_n_s;
            sck_d_r  <= sck_s;
        end
    end

    // Clock edges count only while selected; select edges frame a command
    assign sck_rise = sck_s & ~sck_d_r & ~cs_n_s;
    assign cs_rise  = cs_n_s & ~cs_n_d_r;
    assign cs_fall  = ~cs_n_s & cs_n_d_r;

    // ------------------------------------------------------------------------
    // Bit and byte shifting
    // ------------------------------------------------------------------------
    // Counters and captured bytes of the current frame
    logic [2:0]  bit_cnt_r;
    logic [2:0]  byte_cnt_r;
    logic [7:0]  shift_r;
    logic [7:0]  opcode_r;
    logic [7:0]  sect_r;
    logic        op_valid_r;
    logic [7:0]  shift_nxt;
    logic        byte_done;

    // Data enters at the bottom, so the first bit ends up as the MSB
    assign shift_nxt = {shift_r[6:0], si_s};                           // RQ19
    assign byte_done = sck_rise && (bit_cnt_r == 3'h7);

    // Bit count restarts at every select, so a stray clock cannot skew bytes
    always_ff @(posedge clk_sys) begin
        if (!reset_n || cs_fall) begin
            bit_cnt_r <= 3'h0;
        end else if (sck_rise) begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            shift_r <= 8'h00;
        end else if (sck_rise) begin
            shift_r <= shift_nxt;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n || cs_fall) begin
            byte_cnt_r <= 3'h0;
            op_valid_r <= 1'b0;
            opcode_r   <= 8'h00;
            sect_r     <= 8'h00;
        end else if (byte_done) begin
            // Byte count saturates; bytes past the address are ignored
            if (byte_cnt_r != 3'h7) begin
                byte_cnt_r <= byte_cnt_r + 3'h1;
            end
            if (byte_cnt_r == 3'h0) begin
                opcode_r   <= shift_nxt;
                op_valid_r <= 1'b1;
            end
            // Only the high address byte picks the 64-Kbyte sector
            if (byte_cnt_r == 3'h1) begin
                sect_r <= shift_nxt;                                   // RQ19
            end
        end
    end

    // ------------------------------------------------------------------------
    // Command decode at deselect
    // ------------------------------------------------------------------------
    // Unknown opcodes decode to no command and change nothing
    function automatic sfe_cmd_t decode_op(input logic [7:0] op);
        unique case (op)
            `SFE_OP_CHIP_ERASE_A,
            `SFE_OP_CHIP_ERASE_B: decode_op = SFE_CMD_ERASE;           // RQ1
            `SFE_OP_WRITE_EN:     decode_op = SFE_CMD_WREN;
            `SFE_OP_WRITE_DIS:    decode_op = SFE_CMD_WRDI;
            `SFE_OP_PROTECT:      decode_op = SFE_CMD_PROT;
            `SFE_OP_UNPROTECT:    decode_op = SFE_CMD_UNPROT;
            default:              decode_op = SFE_CMD_NONE;
        endcase
    endfunction

    // Command state seen at deselect
    sfe_cmd_t   cmd;
    logic       aligned;
    logic       addr_ok;
    logic       any_prot;
    logic [3:0] sect_idx;
    sfe_state_t state_r;
    logic       end_cmd;

    assign cmd      = op_valid_r ? decode_op(opcode_r) : SFE_CMD_NONE; // RQ10
    // Select released on a byte boundary
    assign aligned  = (bit_cnt_r == 3'h0);
    // Opcode and all three address bytes arrived
    assign addr_ok  = (byte_cnt_r > `SFE_ADDR_BYTES);
    // Chip erase needs every sector open and none locked down
    assign any_prot = (|sector_protect) | lockdown_any;                // RQ13
    assign sect_idx = sect_r[3:0];
    // Commands are ignored entirely while an erase is running
    assign end_cmd  = cs_rise && (state_r == SFE_ST_IDLE);

    // ------------------------------------------------------------------------
    // Erase sequencer
    // ------------------------------------------------------------------------
    logic [31:0] erase_cnt_r;
    logic        erase_go;
    logic        erase_end;

    // Start only from idle with the latch set and the whole array open
    assign erase_go  = end_cmd && (cmd == SFE_CMD_ERASE) && aligned
                       && write_enable_latch && !any_prot;             // RQ2 RQ3 RQ4 RQ5
    // Busy lasts exactly ERASE_CYCLES cycles from the cycle after start
    assign erase_end = (state_r == SFE_ST_ERASE) && (erase_cnt_r == 32'h0);

    // DONE leaves one cycle before commands are taken again
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state_r <= SFE_ST_IDLE;
        end else begin
            unique case (state_r)
                SFE_ST_IDLE:  if (erase_go) state_r <= SFE_ST_ERASE;
                SFE_ST_ERASE: if (erase_end) state_r <= SFE_ST_DONE;
                SFE_ST_DONE:  state_r <= SFE_ST_IDLE;
                default:      state_r <= SFE_ST_IDLE;
            endcase
        end
    end

    // Loads at start and counts down to zero while erasing
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            erase_cnt_r <= 32'h0;
        end else if (erase_go) begin
            erase_cnt_r <= ERASE_CYCLES - 32'h1;
        end else if (state_r == SFE_ST_ERASE && erase_cnt_r != 32'h0) begin
            erase_cnt_r <= erase_cnt_r - 32'h1;
        end
    end

    // Start pulse for the array model; busy is what status polling sees
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            busy        <= 1'b0;
            erase_start <= 1'b0;
        end else begin
            erase_start <= erase_go;
            busy        <= erase_go || (state_r == SFE_ST_ERASE && !erase_end); // RQ6
        end
    end

    // Sticky until the next erase starts; set and start never share a cycle
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            erase_program_error_flag <= 1'b0;
        end else if (state_r == SFE_ST_ERASE && erase_fail) begin
            erase_program_error_flag <= 1'b1;                          // RQ7
        end else if (erase_go) begin
            erase_program_error_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Write enable latch
    // ------------------------------------------------------------------------
    // Dropped near the end of an erase, so it reads clear before busy falls
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            write_enable_latch <= 1'b0;
        end else if (state_r == SFE_ST_ERASE && erase_cnt_r < `SFE_WEL_CLR_LEFT) begin
            write_enable_latch <= 1'b0;                                // RQ6
        end else if (end_cmd) begin
            unique case (cmd)
                // Enable and disable need a whole opcode on a byte boundary
                SFE_CMD_WREN: if (aligned) write_enable_latch <= 1'b1; // RQ9 RQ10
                SFE_CMD_WRDI: if (aligned) write_enable_latch <= 1'b0; // RQ11 RQ10
                SFE_CMD_ERASE: begin
                    if (!aligned || any_prot) begin
                        write_enable_latch <= 1'b0;                    // RQ4 RQ5
                    end
                end
                // Protect commands drop the latch whether they act or abort
                SFE_CMD_PROT,
                SFE_CMD_UNPROT: begin
                    if (write_enable_latch) begin
                        write_enable_latch <= 1'b0;                    // RQ14 RQ15 RQ16 RQ17 RQ18
                    end
                end
                SFE_CMD_NONE: write_enable_latch <= write_enable_latch;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Sector protection bits
    // ------------------------------------------------------------------------
    logic prot_ok;

    // Needs the latch, a full address on a byte boundary and open registers
    assign prot_ok = end_cmd && aligned && addr_ok && write_enable_latch
                     && !protection_regs_locked_flag;                  // RQ2 RQ15 RQ17 RQ18

    // All sectors come up protected; only the addressed sector changes
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            sector_protect <= `SFE_PROT_RESET;                         // RQ12
        end else if (prot_ok && cmd == SFE_CMD_PROT) begin
            sector_protect[sect_idx] <= 1'b1;                          // RQ14
        end else if (prot_ok && cmd == SFE_CMD_UNPROT) begin
            sector_protect[sect_idx] <= 1'b0;                          // RQ16 RQ13
        end
    end
endmodule

// file: testbench/sfe_asserts.sv
// Port checker for sfe_core.
// Assumes it is bound onto sfe_core and sees only its ports.
`timescale 1ns/100ps
`include "sfe_cfg.svh"
module sfe_asserts #(
    parameter int unsigned ERASE_CYCLES = 200
) (
    // Clock and reset
    clk_sys,
    reset_n,
    // Serial pins
    spi_cs_n,
    spi_sck,
    spi_si,
    // Status inputs
    protection_regs_locked_flag,
    lockdown_any,
    erase_fail,
    // Status outputs
    busy,
    write_enable_latch,
    erase_program_error_flag,
    sector_protect,
    erase_start
);
    input wire logic                          clk_sys;
    input wire logic                          reset_n;
    input wire logic                          spi_cs_n;
    input wire logic                          spi_sck;
    input wire logic                          spi_si;
    input wire logic                          protection_regs_locked_flag;
    input wire logic                          lockdown_any;
    input wire logic                          erase_fail;
    input wire logic                          busy;
    input wire logic                          write_enable_latch;
    input wire logic                          erase_program_error_flag;
    input wire logic [`SFE_NUM_SECTORS-1:0]   sector_protect;
    input wire logic                          erase_start;
    int unsigned busy_cnt_r;
    // Counts cycles of the current busy spell
    always_ff @(posedge clk_sys) begin
        if (!reset_n || !busy)
            busy_cnt_r <= 0;
        else
            busy_cnt_r <= busy_cnt_r + 1;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    chk_start_busy: assert property (erase_start |-> ##[0:1] busy)
        else $error("busy missing after erase start");
    chk_start_wel: assert property (erase_start |-> $past(write_enable_latch))
        else $error("erase started without latch");
    chk_start_clear: assert property (erase_start |-> sector_protect == '0 && !lockdown_any)
        else $error("erase started with protected sector");
    chk_start_idle: assert property (erase_start |-> !$past(busy) && spi_cs_n)
        else $error("erase started while busy or selected");
    chk_busy_len: assert property ($fell(busy) |-> busy_cnt_r == ERASE_CYCLES)
        else $error("erase length wrong");
    chk_wel_end: assert property ($fell(busy) |-> !$past(write_enable_latch))
        else $error("latch still set at erase end");
    chk_err_set: assert property (busy && erase_fail |-> ##[0:2] erase_program_error_flag)
        else $error("erase failure not flagged");
    chk_wel_rise: assert property ($rose(write_enable_latch) |-> spi_cs_n && !busy)
        else $error("latch set while selected");
    chk_prot_cs: assert property (!$stable(sector_protect) |-> spi_cs_n && $past(write_enable_latch))
        else $error("protect bits changed without latch");
    chk_prot_lock: assert property ($past(protection_regs_locked_flag) |-> $stable(sector_protect))
        else $error("protect bits changed while locked");
endmodule

// file: testbench/sfe_host.sv
// Host serial controller model, mode 0, 160 ns serial clock.
// Assumes the bench calls frame and waits for it to return.
`timescale 1ns/100ps
module sfe_host (
    // Serial pins
    spi_cs_n,
    spi_sck,
    spi_si
);
    output logic spi_cs_n;
    output logic spi_sck;
    output logic spi_si;
    initial begin
        spi_cs_n = 1'b1;
        spi_sck = 1'b0;
        spi_si = 1'b0;
    end
    // Clock stands low between frames; data inverts when deselected
    task automatic frame(input logic [39:0] d, input int n);
        spi_cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            spi_si = d[39-i];
            #80 spi_sck = 1'b1;
            #80 spi_sck = 1'b0;
        end
        #40 spi_cs_n = 1'b1;
        spi_si = ~spi_si;
        #400;
    endtask
endmodule

// file: testbench/tb_top.sv
// Self-checking bench: host model drives sfe_core, a reference model predicts.
// Assumes sfe_host, sfe_asserts and the common files compiled first.
`timescale 1ns/100ps
`include "sfe_cfg.svh"
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin err_total++; \
    $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module tb_top;
    import sfe_pkg::*;
    localparam int unsigned ERASE_CYCLES = 200;
    logic clk_sys, reset_n, protection_regs_locked_flag, lockdown_any, erase_fail;
    logic busy, write_enable_latch, erase_program_error_flag, erase_start, m_wel, m_err;
    logic [`SFE_NUM_SECTORS-1:0] sector_protect, m_prot;
    wire logic spi_cs_n, spi_sck, spi_si;
    int err_total, n_compared, starts, m_starts;
    logic [31:0] rnd;
    logic [7:0] ops[$] = '{8'h06, 8'h06, 8'h04, 8'h60, 8'hC7, 8'h36, 8'h39, 8'h9F};
    int lens[$] = '{8, 16, 32, 40, 5, 13, 31, 24};
    sfe_host i_sfe_host (.spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_si(spi_si));
    sfe_core #(.ERASE_CYCLES(ERASE_CYCLES)) i_sfe_core (.clk_sys(clk_sys), .reset_n(reset_n),
        .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_si(spi_si),
        .protection_regs_locked_flag(protection_regs_locked_flag), .lockdown_any(lockdown_any),
        .erase_fail(erase_fail), .busy(busy), .write_enable_latch(write_enable_latch),
        .erase_program_error_flag(erase_program_error_flag), .sector_protect(sector_protect),
        .erase_start(erase_start));
    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function automatic logic [31:0] xs();
        rnd ^= rnd << 13;
        rnd ^= rnd >> 17;
        rnd ^= rnd << 5;
        return rnd;
    endfunction
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic cmd(input logic [7:0] op, input int nb, input logic [23:0] adr);
        logic go;
        logic ok;
        ok = (nb % 8 == 0);
        go = 1'b0;
        if (nb >= 8) begin
            case (op)
                `SFE_OP_WRITE_EN: if (ok) m_wel = 1'b1;
                `SFE_OP_WRITE_DIS: if (ok) m_wel = 1'b0;
                `SFE_OP_CHIP_ERASE_A, `SFE_OP_CHIP_ERASE_B: if (m_wel) begin
                    go = ok && m_prot == '0 && !lockdown_any;
                    m_wel = 1'b0;
                end
                `SFE_OP_PROTECT, `SFE_OP_UNPROTECT: if (m_wel) begin
                    if (ok && nb >= 32 && !protection_regs_locked_flag)
                        m_prot[adr[19:16]] = (op == `SFE_OP_PROTECT);
                    m_wel = 1'b0;
                end
                default: ;
            endcase
        end
        if (go) begin
            m_starts++;
            m_err = erase_fail;
        end
        i_sfe_host.frame({op, adr, 8'hA5}, nb);
        `CHK("busy", go, busy)
        repeat (ERASE_CYCLES + 20) if (busy === 1'b1) @(posedge clk_sys);
        @(posedge clk_sys) #1;
        `CHK("idle", 1'b0, busy)
        `CHK("wel", m_wel, write_enable_latch)
        `CHK("prot", m_prot, sector_protect)
        `CHK("err", m_err, erase_program_error_flag)
        `CHK("starts", m_starts, starts)
    endtask
    // ------------------------------------------------------------------------
    // Clock, watchdog, sequence
    // ------------------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) if (erase_start === 1'b1) starts++;
    initial begin
        #1_000_000;
        err_total++;
        summarize();
    end
    initial begin
        logic [31:0] r;
        {reset_n, protection_regs_locked_flag, lockdown_any, erase_fail, m_wel, m_err} = 6'h00;
        {rnd, starts, m_starts, err_total, n_compared} = {32'h0000_005A, 128'h0};
        m_prot = `SFE_PROT_RESET;
        repeat (6) @(posedge clk_sys);
        #1 reset_n = 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        `CHK("prot_reset", `SFE_PROT_RESET, sector_protect)
        cmd(`SFE_OP_WRITE_EN, 8, 0);
        cmd(`SFE_OP_CHIP_ERASE_A, 8, 0);
        for (int s = 0; s < 16; s++) begin
            cmd(`SFE_OP_WRITE_EN, 16, 0);
            cmd(`SFE_OP_UNPROTECT, 32 + 8 * (s % 2), {4'h0, 4'(s), 16'(xs())});
        end
        @(posedge clk_sys) #1 lockdown_any = 1'b1;
        cmd(`SFE_OP_WRITE_EN, 8, 0);
        cmd(`SFE_OP_CHIP_ERASE_B, 8, 0);
        @(posedge clk_sys) #1 lockdown_any = 1'b0;
        erase_fail = 1'b1;
        cmd(`SFE_OP_WRITE_EN, 8, 0);
        cmd(`SFE_OP_CHIP_ERASE_A, 8, 0);
        @(posedge clk_sys) #1 erase_fail = 1'b0;
        cmd(`SFE_OP_WRITE_EN, 8, 0);
        cmd(`SFE_OP_CHIP_ERASE_B, 16, 0);
        for (int k = 0; k < 50; k++) begin
            r = xs();
            @(posedge clk_sys) #1;
            {protection_regs_locked_flag, lockdown_any, erase_fail} = {&r[3:2], &r[7:5], r[9]};
            cmd(ops[r[14:12]], lens[r[18:16]], r[31:8]);
        end
        summarize();
    end
endmodule
bind sfe_core sfe_asserts #(.ERASE_CYCLES(ERASE_CYCLES)) i_sfe_asserts (.clk_sys(clk_sys),
    .reset_n(reset_n), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_si(spi_si),
    .protection_regs_locked_flag(protection_regs_locked_flag), .lockdown_any(lockdown_any),
    .erase_fail(erase_fail), .busy(busy), .write_enable_latch(write_enable_latch),
    .erase_program_error_flag(erase_program_error_flag), .sector_protect(sector_protect),
    .erase_start(erase_start));
